/* verilog/bwds_pkg.sv */
// constants and carriers for the bridge window decode and status block
package bwds_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [9:0] IDX_LAT = 10'h01B;
    localparam logic [9:0] IDX_IOBOT = 10'h01C;
    localparam logic [9:0] IDX_IOTOP = 10'h01D;
    localparam logic [9:0] IDX_STS = 10'h01E;
    localparam logic [9:0] IDX_MBOT = 10'h020;
    localparam logic [9:0] IDX_MTOP = 10'h022;

    // field positions
    localparam int IO_FLD_HI = 7;
    localparam int IO_FLD_LO = 4;
    localparam int MEM_FLD_HI = 15;
    localparam int MEM_FLD_LO = 4;
    localparam int STS_PARITY = 15;
    localparam int STS_SYS_ERR = 14;
    localparam int STS_MST_ABORT = 13;
    localparam int STS_TGT_ABORT = 12;
    localparam int STS_SIG_ABORT = 11;
    localparam int STS_SEL_HI = 10;
    localparam int STS_SEL_LO = 9;
    localparam int STS_MST_PARITY = 8;
    localparam int STS_B2B = 7;
    localparam int STS_FAST = 5;

    // reset values
    localparam logic [7:0] LAT_RST = 8'h00;
    localparam logic [7:0] IOBOT_RST = 8'hF0;
    localparam logic [7:0] IOTOP_RST = 8'h00;
    localparam logic [15:0] STS_RST = 16'h02A0;
    localparam logic [15:0] MBOT_RST = 16'hFFF0;
    localparam logic [15:0] MTOP_RST = 16'h0000;

    // implied low address bits of window edges, and zero pad above 16-bit I/O addresses
    localparam logic [11:0] IO_LOW_FILL = 12'h000;
    localparam logic [11:0] IO_HIGH_FILL = 12'hFFF;
    localparam logic [19:0] MEM_LOW_FILL = 20'h00000;
    localparam logic [19:0] MEM_HIGH_FILL = 20'hFFFFF;
    localparam logic [15:0] IO_ADDR_PAD = 16'h0000;

    // select timing code for medium decode
    localparam logic [1:0] SEL_MEDIUM = 2'h1;

    // programmed window edges
    typedef struct packed {
        logic [3:0] io_bot;
        logic [3:0] io_top;
        logic [11:0] mem_bot;
        logic [11:0] mem_top;
    } bwds_win_s;

    // sticky secondary-side error flags
    typedef struct packed {
        logic sys_err;
        logic mst_abort;
        logic tgt_abort;
    } bwds_evt_s;

endpackage : bwds_pkg

/* verilog/bwds_top.sv */
// window decode and secondary status slice of a virtual bridge, APB slave
//
// Chosen here: the APB slave port.
`timescale 1ns/1ns
// How it works
// [R1] forward I/O only inside programmed I/O window
// [R2] I/O bottom field gives A15:12, low zeros
// [R3] I/O top field gives A15:12, low ones
// [R4] forward memory only inside programmed memory window
// [R5] memory registers bits 15:4 writable, A31:20
// [R6] memory registers bits 3:0 read zero
// [R7] memory bottom assumes A19:0 zero
// [R8] memory top assumes A19:0 all ones
// [R9] software initialises memory windows before use
// [R10] software keeps windows from overlapping
// [R11] hardware never checks window overlap
// [R12] write one clears status bit, zero keeps
// [R13] link system error sets status bit 14
// [R14] unexpected master abort sets status bit 13
// [R15] target abort received sets status bit 12
// [R16] bits 10:9 read 01, medium select timing
// [R17] bit 15 reads zero, no parity
// [R18] bit 11 reads zero, never target abort
// [R19] bit 8 reads zero, no parity pin
// [R20] bit 7 reads one, back-to-back accepted
// [R21] bit 5 reads one, 66 MHz capable
// [R22] reset windows empty, nothing forwarded
module bwds_top (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] IO_ADDR,
    output logic IO_FWD,
    input wire logic [31:0] MEM_ADDR,
    output logic MEM_FWD,
    input wire logic SYS_ERR_EVT,
    input wire logic MST_ABORT_EVT,
    input wire logic TGT_ABORT_EVT,
    output logic [1:0] SEL_TIMING,
    output logic B2B_ACCEPT
);

    bwds_pkg::bwds_win_s win_reg;
    bwds_pkg::bwds_win_s win_next;
    bwds_pkg::bwds_evt_s evt_reg;
    bwds_pkg::bwds_evt_s evt_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic err_reg;
    logic err_next;
    logic [9:0] idx;
    logic setup;
    logic wr;
    logic mapped;
    logic [15:0] sts_word;
    logic [31:0] rd_word;

    // inclusive window compare
    function automatic logic in_range(
        input logic [31:0] a,
        input logic [31:0] lo,
        input logic [31:0] hi
    );
        in_range = (lo <= a) && (a <= hi);
    endfunction : in_range

    // read image of the status register
    function automatic logic [15:0] status_image(input bwds_pkg::bwds_evt_s e);
        logic [15:0] s;
        s = bwds_pkg::STS_RST;
        s[bwds_pkg::STS_PARITY] = 1'b0; // [R17]
        s[bwds_pkg::STS_SIG_ABORT] = 1'b0; // [R18]
        s[bwds_pkg::STS_SEL_HI:bwds_pkg::STS_SEL_LO] = bwds_pkg::SEL_MEDIUM; // [R16]
        s[bwds_pkg::STS_MST_PARITY] = 1'b0; // [R19]
        s[bwds_pkg::STS_B2B] = 1'b1; // [R20]
        s[bwds_pkg::STS_FAST] = 1'b1; // [R21]
        s[bwds_pkg::STS_SYS_ERR] = e.sys_err;
        s[bwds_pkg::STS_MST_ABORT] = e.mst_abort;
        s[bwds_pkg::STS_TGT_ABORT] = e.tgt_abort;
        status_image = s;
    endfunction : status_image

    assign idx = PADDR[11:2];
    assign setup = PSEL && !PENABLE;
    // slave never inserts wait states, so every access phase completes
    assign wr = PSEL && PENABLE && PWRITE;
    assign PREADY = 1'b1;
    assign PRDATA = rdata_reg;
    assign PSLVERR = err_reg;
    assign SEL_TIMING = bwds_pkg::SEL_MEDIUM; // [R16]
    assign B2B_ACCEPT = 1'b1; // [R20]
    assign sts_word = status_image(evt_reg);

    // address decode; overlapping windows are neither detected nor blocked [R11]
    always_comb
    begin
        IO_FWD = in_range({bwds_pkg::IO_ADDR_PAD, IO_ADDR},
            {bwds_pkg::IO_ADDR_PAD, win_reg.io_bot, bwds_pkg::IO_LOW_FILL}, // [R2]
            {bwds_pkg::IO_ADDR_PAD, win_reg.io_top, bwds_pkg::IO_HIGH_FILL}); // [R1] [R3]
        MEM_FWD = in_range(MEM_ADDR,
            {win_reg.mem_bot, bwds_pkg::MEM_LOW_FILL}, // [R7]
            {win_reg.mem_top, bwds_pkg::MEM_HIGH_FILL}); // [R4] [R8]
    end

    // window registers, byte lanes honoured
    always_comb
    begin
        win_next = win_reg;
        if (wr && idx == bwds_pkg::IDX_IOBOT && PSTRB[0])
        begin
            win_next.io_bot = PWDATA[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO];
        end
        if (wr && idx == bwds_pkg::IDX_IOTOP && PSTRB[0])
        begin
            win_next.io_top = PWDATA[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO];
        end
        if (wr && idx == bwds_pkg::IDX_MBOT)
        begin
            if (PSTRB[0])
            begin
                win_next.mem_bot[3:0] = PWDATA[7:4]; // [R5]
            end
            if (PSTRB[1])
            begin
                win_next.mem_bot[11:4] = PWDATA[15:8]; // [R5]
            end
        end
        if (wr && idx == bwds_pkg::IDX_MTOP)
        begin
            if (PSTRB[0])
            begin
                win_next.mem_top[3:0] = PWDATA[7:4]; // [R5]
            end
            if (PSTRB[1])
            begin
                win_next.mem_top[11:4] = PWDATA[15:8]; // [R5]
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            win_reg.io_bot <= bwds_pkg::IOBOT_RST[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO]; // [R22]
            win_reg.io_top <= bwds_pkg::IOTOP_RST[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO]; // [R22]
            win_reg.mem_bot <= bwds_pkg::MBOT_RST[bwds_pkg::MEM_FLD_HI:bwds_pkg::MEM_FLD_LO]; // [R22]
            win_reg.mem_top <= bwds_pkg::MTOP_RST[bwds_pkg::MEM_FLD_HI:bwds_pkg::MEM_FLD_LO]; // [R22]
        end
        else
        begin
            win_reg <= win_next;
        end
    end

    // sticky flags: an event in the clearing cycle keeps the flag set
    always_comb
    begin
        logic clr_ok;
        clr_ok = wr && idx == bwds_pkg::IDX_STS && PSTRB[1];
        evt_next = evt_reg;
        if (clr_ok && PWDATA[bwds_pkg::STS_SYS_ERR])
        begin
            evt_next.sys_err = 1'b0; // [R12]
        end
        if (clr_ok && PWDATA[bwds_pkg::STS_MST_ABORT])
        begin
            evt_next.mst_abort = 1'b0; // [R12]
        end
        if (clr_ok && PWDATA[bwds_pkg::STS_TGT_ABORT])
        begin
            evt_next.tgt_abort = 1'b0; // [R12]
        end
        if (SYS_ERR_EVT)
        begin
            evt_next.sys_err = 1'b1; // [R13]
        end
        if (MST_ABORT_EVT)
        begin
            evt_next.mst_abort = 1'b1; // [R14]
        end
        if (TGT_ABORT_EVT)
        begin
            evt_next.tgt_abort = 1'b1; // [R15]
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            evt_reg <= '0;
        end
        else
        begin
            evt_reg <= evt_next;
        end
    end

    // read data and error are captured in the setup cycle
    always_comb
    begin
        mapped = 1'b1;
        rd_word = 32'h00000000;
        unique case (idx)
            bwds_pkg::IDX_LAT:
            begin
                rd_word[7:0] = bwds_pkg::LAT_RST;
            end
            bwds_pkg::IDX_IOBOT:
            begin
                rd_word[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO] = win_reg.io_bot;
            end
            bwds_pkg::IDX_IOTOP:
            begin
                rd_word[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO] = win_reg.io_top;
            end
            bwds_pkg::IDX_STS:
            begin
                rd_word[15:0] = sts_word;
            end
            bwds_pkg::IDX_MBOT:
            begin
                rd_word[bwds_pkg::MEM_FLD_HI:bwds_pkg::MEM_FLD_LO] = win_reg.mem_bot; // [R6]
            end
            bwds_pkg::IDX_MTOP:
            begin
                rd_word[bwds_pkg::MEM_FLD_HI:bwds_pkg::MEM_FLD_LO] = win_reg.mem_top; // [R6]
            end
            default:
            begin
                mapped = 1'b0;
            end
        endcase
        rdata_next = rdata_reg;
        err_next = err_reg;
        if (setup)
        begin
            rdata_next = PWRITE ? 32'h00000000 : rd_word;
            err_next = !mapped;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            rdata_reg <= 32'h00000000;
            err_reg <= 1'b0;
        end
        else
        begin
            rdata_reg <= rdata_next;
            err_reg <= err_next;
        end
    end

    io_bottom_edge_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
        IO_FWD |-> IO_ADDR[15:12] >= win_reg.io_bot)
        else $error("io forward below window bottom");

    io_top_edge_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
        (IO_ADDR[15:12] == win_reg.io_top && win_reg.io_top >= win_reg.io_bot) |-> IO_FWD)
        else $error("io top block not forwarded");

    io_window_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R1]
        IO_FWD |-> IO_ADDR[15:12] <= win_reg.io_top)
        else $error("io forward above window top");

    mem_bottom_edge_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R7]
        (MEM_ADDR[31:20] == win_reg.mem_bot && win_reg.mem_bot <= win_reg.mem_top) |-> MEM_FWD)
        else $error("memory bottom block not forwarded");

    mem_top_edge_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
        MEM_FWD |-> MEM_ADDR[31:20] <= win_reg.mem_top && MEM_ADDR[31:20] >= win_reg.mem_bot)
        else $error("memory forward outside window");

    mem_field_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
        (wr && idx == bwds_pkg::IDX_MTOP && PSTRB[1:0] == 2'h3)
        |=> win_reg.mem_top == $past(PWDATA[15:4]))
        else $error("memory top field not written");

    mem_low_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R6]
        (setup && !PWRITE && (idx == bwds_pkg::IDX_MBOT || idx == bwds_pkg::IDX_MTOP))
        |=> PRDATA[3:0] == 4'h0 ##1 PRDATA[3:0] == 4'h0)
        else $error("memory low bits not zero");

    sys_err_set_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R13]
        SYS_ERR_EVT |=> evt_reg.sys_err)
        else $error("system error flag not set");

    abort_set_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
        MST_ABORT_EVT |=> evt_reg.mst_abort)
        else $error("master abort flag not set");

    tgt_abort_set_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R15]
        TGT_ABORT_EVT |=> evt_reg.tgt_abort)
        else $error("target abort flag not set");

    status_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
        (wr && idx == bwds_pkg::IDX_STS && PSTRB[1] && PWDATA[14] && !SYS_ERR_EVT)
        |=> !evt_reg.sys_err)
        else $error("system error flag not cleared");

    status_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
        (evt_reg.mst_abort && !(wr && idx == bwds_pkg::IDX_STS && PSTRB[1] && PWDATA[13]))
        |=> evt_reg.mst_abort)
        else $error("master abort flag lost");

    fixed_bits_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R16] [R17] [R18] [R19] [R20] [R21]
        (setup && !PWRITE && idx == bwds_pkg::IDX_STS)
        |=> PRDATA[10:9] == 2'h1 && !PRDATA[15] && !PRDATA[11] && !PRDATA[8] && PRDATA[7] && PRDATA[5])
        else $error("hardwired status bits wrong");

    reset_empty_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R22]
        $past(SYS_RST) |-> !IO_FWD && !MEM_FWD)
        else $error("forwarding right after reset");

    io_bottom_hit_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
        (IO_ADDR[15:12] == win_reg.io_bot && win_reg.io_bot <= win_reg.io_top)
        |-> IO_FWD)
        else $error("io bottom block not forwarded");

    mem_top_hit_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
        (MEM_ADDR[31:20] == win_reg.mem_top && win_reg.mem_bot <= win_reg.mem_top)
        |-> MEM_FWD)
        else $error("memory top block not forwarded");

    io_bottom_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
        (wr && idx == bwds_pkg::IDX_IOBOT && PSTRB[0])
        |=> win_reg.io_bot == $past(PWDATA[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO]))
        else $error("io bottom field not written");

    io_top_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
        (wr && idx == bwds_pkg::IDX_IOTOP && PSTRB[0])
        |=> win_reg.io_top == $past(PWDATA[bwds_pkg::IO_FLD_HI:bwds_pkg::IO_FLD_LO]))
        else $error("io top field not written");

    mem_bottom_write_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
        (wr && idx == bwds_pkg::IDX_MBOT && PSTRB[1:0] == 2'h3)
        |=> win_reg.mem_bot == $past(PWDATA[bwds_pkg::MEM_FLD_HI:bwds_pkg::MEM_FLD_LO]))
        else $error("memory bottom field not written");

    abort_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
        (wr && idx == bwds_pkg::IDX_STS && PSTRB[1] && PWDATA[bwds_pkg::STS_MST_ABORT] && !MST_ABORT_EVT)
        |=> !evt_reg.mst_abort)
        else $error("master abort flag not cleared");

    tgt_clear_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
        (wr && idx == bwds_pkg::IDX_STS && PSTRB[1] && PWDATA[bwds_pkg::STS_TGT_ABORT] && !TGT_ABORT_EVT)
        |=> !evt_reg.tgt_abort)
        else $error("target abort flag not cleared");

    sys_err_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
        (evt_reg.sys_err && !(wr && idx == bwds_pkg::IDX_STS && PSTRB[1] && PWDATA[bwds_pkg::STS_SYS_ERR]))
        |=> evt_reg.sys_err)
        else $error("system error flag lost");

    tgt_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
        (evt_reg.tgt_abort && !(wr && idx == bwds_pkg::IDX_STS && PSTRB[1] && PWDATA[bwds_pkg::STS_TGT_ABORT]))
        |=> evt_reg.tgt_abort)
        else $error("target abort flag lost");

    reset_order_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R22]
        $past(SYS_RST)
        |-> win_reg.io_bot > win_reg.io_top && win_reg.mem_bot > win_reg.mem_top)
        else $error("reset windows not empty");

endmodule : bwds_top

/* bench/bwds_link_model.sv */
// behavioural device on the secondary link that raises error pulses
`timescale 1ns/1ns
module bwds_link_model (
    input wire logic clk,
    input wire logic serr_req,
    input wire logic tabt_req,
    output logic serr,
    output logic tabt
);
    initial
    begin
        serr = 1'b0;
        tabt = 1'b0;
    end
    // one-cycle pulses launched just after a rising edge
    always @(posedge clk)
    begin
        serr <= serr_req;
        tabt <= tabt_req;
    end
endmodule : bwds_link_model

/* bench/bwds_top_tb.sv */
// self-checking bench for the window decode and status block
`timescale 1ns/1ns
module bwds_top_tb;
    logic clk, rst, psel, penable, pwrite, mreq, sreq, treq, serr, tabt, pready, pslverr, io_fwd, mem_fwd, b2b, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, mem_addr, rd;
    logic [3:0] pstrb;
    logic [15:0] io_addr;
    logic [1:0] sel;
    int mismatches, n_tests;
    bwds_top u_dut (
        .CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .IO_ADDR(io_addr), .IO_FWD(io_fwd), .MEM_ADDR(mem_addr),
        .MEM_FWD(mem_fwd), .SYS_ERR_EVT(serr), .MST_ABORT_EVT(mreq), .TGT_ABORT_EVT(tabt),
        .SEL_TIMING(sel), .B2B_ACCEPT(b2b)
    );
    bwds_link_model u_link (.clk(clk), .serr_req(sreq), .tabt_req(treq), .serr(serr), .tabt(tabt));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    // one apb transfer; waits for pready under a bound
    task automatic apb(input logic w, input logic [9:0] i, input logic [31:0] d, input logic [3:0] s);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            mismatches++;
            give_verdict;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task rdchk(input logic [9:0] i, input logic [31:0] exp);
        apb(1'b0, i, 32'h0, 4'h0);
        chk(rd, exp, "register read");
        chk(er, 32'h0, "mapped error");
    endtask : rdchk
    task fwd(input logic [15:0] ia, input logic [31:0] ma, input logic ei, input logic em);
        io_addr <= ia;
        mem_addr <= ma;
        @(negedge clk);
        chk(io_fwd, ei, "io forward");
        chk(mem_fwd, em, "memory forward");
        @(posedge clk);
    endtask : fwd
    task t_reset;
        rdchk(bwds_pkg::IDX_LAT, 32'h0);
        rdchk(bwds_pkg::IDX_IOBOT, 32'hF0);
        rdchk(bwds_pkg::IDX_IOTOP, 32'h0);
        rdchk(bwds_pkg::IDX_STS, 32'h2A0);
        rdchk(bwds_pkg::IDX_MBOT, 32'hFFF0);
        rdchk(bwds_pkg::IDX_MTOP, 32'h0);
        fwd(16'hF000, 32'hFFF00000, 1'b0, 1'b0);
        fwd(16'h0000, 32'h0, 1'b0, 1'b0);
        chk(sel, 32'h1, "select timing");
        chk(b2b, 32'h1, "back to back");
        apb(1'b0, 10'h021, 32'h0, 4'h0);
        chk(er, 32'h1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
    endtask : t_reset
    task t_io;
        apb(1'b1, bwds_pkg::IDX_IOBOT, 32'h3F, 4'h1);
        apb(1'b1, bwds_pkg::IDX_IOTOP, 32'h5F, 4'h1);
        rdchk(bwds_pkg::IDX_IOBOT, 32'h30);
        rdchk(bwds_pkg::IDX_IOTOP, 32'h50);
        fwd(16'h2FFF, 32'h0, 1'b0, 1'b0);
        fwd(16'h3000, 32'h0, 1'b1, 1'b0);
        fwd(16'h5FFF, 32'h0, 1'b1, 1'b0);
        fwd(16'h6000, 32'h0, 1'b0, 1'b0);
    endtask : t_io
    task t_mem;
        apb(1'b1, bwds_pkg::IDX_MBOT, 32'h123F, 4'h3);
        apb(1'b1, bwds_pkg::IDX_MTOP, 32'h125F, 4'h3);
        rdchk(bwds_pkg::IDX_MBOT, 32'h1230);
        rdchk(bwds_pkg::IDX_MTOP, 32'h1250);
        fwd(16'h0, 32'h122FFFFF, 1'b0, 1'b0);
        fwd(16'h0, 32'h12300000, 1'b0, 1'b1);
        fwd(16'h0, 32'h125FFFFF, 1'b0, 1'b1);
        fwd(16'h0, 32'h12600000, 1'b0, 1'b0);
    endtask : t_mem
    task t_sts;
        sreq <= 1'b1;
        treq <= 1'b1;
        mreq <= 1'b1;
        @(posedge clk);
        sreq <= 1'b0;
        treq <= 1'b0;
        mreq <= 1'b0;
        repeat (2) @(posedge clk);
        rdchk(bwds_pkg::IDX_STS, 32'h72A0);
        apb(1'b1, bwds_pkg::IDX_STS, 32'h4000, 4'h3);
        rdchk(bwds_pkg::IDX_STS, 32'h32A0);
        apb(1'b1, bwds_pkg::IDX_STS, 32'h0, 4'h3);
        rdchk(bwds_pkg::IDX_STS, 32'h32A0);
        apb(1'b1, bwds_pkg::IDX_STS, 32'hFFFF, 4'h3);
        rdchk(bwds_pkg::IDX_STS, 32'h2A0);
        // abort pulse lands on the clearing edge; the set must win
        fork
            apb(1'b1, bwds_pkg::IDX_STS, 32'h2000, 4'h3);
            begin
                @(posedge clk);
                mreq <= 1'b1;
                @(posedge clk);
                mreq <= 1'b0;
            end
        join
        rdchk(bwds_pkg::IDX_STS, 32'h22A0);
        apb(1'b1, bwds_pkg::IDX_STS, 32'h2000, 4'h1);
        rdchk(bwds_pkg::IDX_STS, 32'h22A0);
        apb(1'b1, bwds_pkg::IDX_STS, 32'h2000, 4'h2);
        rdchk(bwds_pkg::IDX_STS, 32'h2A0);
    endtask : t_sts
    task t_ro;
        apb(1'b1, bwds_pkg::IDX_LAT, 32'hFF, 4'hF);
        rdchk(bwds_pkg::IDX_LAT, 32'h0);
        apb(1'b1, 10'h021, 32'hFF, 4'hF);
        chk(er, 32'h1, "unmapped write");
    endtask : t_ro
    initial
    begin
        mismatches = 0;
        n_tests = 0;
        rst = 1'b1;
        {psel, penable, pwrite, mreq, sreq, treq} = 6'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        pstrb = 4'h0;
        io_addr = 16'h0;
        mem_addr = 32'h0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_io;
        t_mem;
        t_sts;
        t_ro;
        give_verdict;
    end
endmodule : bwds_top_tb
